//--- shared/adc_conv_defs.svh
/*
 * Register offsets, field positions, reset values and converter-clock
 * counts for the converter control block.
 * Assumes it is included by bare name from files that need it.
 */
`ifndef ADC_CONV_DEFS_SVH
`define ADC_CONV_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ADC_CH_EN_LOW_ADDR   8'hab
`define ADC_CTRL_ADDR        8'hac
`define ADC_RES_HIGH_ADDR    8'had
`define ADC_RES_LOW_ADDR     8'hae
`define ADC_CLK_SEL_ADDR     8'haf
`define ADC_SH_ADDR          8'hef
`define ADC_CAL_ADDR         16'hffff

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define ADC_CTRL_START       7
`define ADC_CTRL_ALIGN       6
`define ADC_CTRL_MODE        5
`define ADC_CTRL_FWCTL       4
`define ADC_CLK_BGEN         7
`define ADC_CLK_CH8EN        6
`define ADC_CAL_EN           1
`define ADC_CAL_START        0
`define ADC_CAL_RESET        8'h02
`define ADC_REG_RESET        8'h00

// ----------------------------------------------------------------------
// divider factor and counts in converter clocks
// ----------------------------------------------------------------------
`define ADC_DIV_FACTOR       8'h06
`define ADC_HW_SAMPLE_ZERO   9'h004
`define ADC_HW_SAMPLE_BASE   9'h007
`define ADC_HW_CONV_CLKS     9'h00c
`define ADC_FW_CONV_CLKS     9'h010
`define ADC_CAL_CLKS         9'h040
`define ADC_CAL_EXTRA_CLKS   9'h004

`endif

//--- shared/adc_conv_pkg.sv
/*
 * Types shared by the converter control files.
 * Assumes nothing of its surroundings.
 */
package adc_conv_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_CALIB} adc_state_type;
endpackage : adc_conv_pkg

//--- core/adc_clock_divider.sv
/*
 * Converter clock divider: one tick every 6*(divider_value+1) system clocks.
 * Assumes divider_value comes from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "adc_conv_defs.svh"

module adc_clock_divider (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic [4:0] divider_value,
    output logic            tick,
    output logic            clk_level
);
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic       tick_reg;
    logic       tick_next;
    logic       level_reg;
    logic       level_next;
    logic [7:0] limit;

    always_comb
    begin
        limit      = (({3'h0, divider_value} + 8'h01) * `ADC_DIV_FACTOR) - 8'h01; // [R11]
        tick_next  = (cnt_reg >= limit);
        cnt_next   = tick_next ? 8'h00 : cnt_reg + 8'h01;
        level_next = (cnt_next <= (limit >> 1));
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_reg   <= 8'h00;
            tick_reg  <= 1'b0;
            level_reg <= 1'b0;
        end
        else
        begin
            cnt_reg   <= cnt_next;
            tick_reg  <= tick_next;
            level_reg <= level_next;
        end
    end

    assign tick      = tick_reg;
    assign clk_level = level_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence quiet_five;
        (!tick_reg && divider_value == 5'h00)[*5];
    endsequence

    AST_DIV_PERIOD: assert property (@(posedge mclk) disable iff (sys_rst) // [R11]
        (tick_reg && divider_value == 5'h00) ##1 quiet_five |=> tick_reg)
        else $error("converter clock period wrong for divider zero");

endmodule : adc_clock_divider
`default_nettype wire

//--- core/adc_conversion_control.sv
/*
 * Converter control: special function registers, indirect calibration
 * register, sampling and conversion sequencer, result alignment and
 * conversion-end flag.
 * Assumes an analog core whose result settles before the end of the
 * conversion phase; its data pins are synchronised here.
 */
// Function
// R1: twelve-bit result, nine external inputs offered to the converter.
// R2: enable bits for channels 0..7, bit n for channel n.
// R3: channel 8 enable in bit 6 of the clock-select register.
// R4: setting start begins one single-shot conversion.
// R5: alignment 0: high byte holds bits 11..4, low nibble bits 3..0.
// R6: alignment 1: high nibble reads zero, low byte holds bits 7..0.
// R7: sampling-mode 0 times sampling by hardware, 1 follows firmware bit.
// R8: firmware bit drives sampler in firmware mode, ignored in hardware mode.
// R9: select codes 0..8 route channels, other codes route bandgap.
// R10: bandgap enable in bit 7 of clock-select gates reference in.
// R11: converter clock is system clock over six times (divider plus one).
// R12: hardware mode lasts 16 clocks, or 19 plus sample-hold when nonzero.
// R13: firmware mode lasts the firmware sample interval plus 16 clocks.
// R14: calibration enabled with channel enabled lengthens each conversion.
// R15: calibration start launches calibration, hardware clears it when done.
// R16: software writes 0x00 then 0x03, then polls bit 0 for zero.
// R17: conversion end sets the flag, vector entry clears it.
// R18: interrupt request is the flag gated by the interrupt enable.
// R19: start self-clears at completion, result updates at the same moment.
// R20: start requests during conversion or calibration are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "adc_conv_defs.svh"

module adc_conversion_control (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    input  wire logic [15:0] xram_addr,
    input  wire logic        xram_wr,
    input  wire logic        xram_rd,
    input  wire logic [7:0]  xram_wdata,
    output logic      [7:0]  xram_rdata,
    input  wire logic        conversion_irq_enable,
    input  wire logic        irq_vector_ack,
    input  wire logic [11:0] adc_core_data,
    output logic      [8:0]  converter_channel_n_enable,
    output logic      [9:0]  analog_route,
    output logic             sample_active,
    output logic             convert_active,
    output logic             converter_clock,
    output logic             conversion_end_flag,
    output logic             conversion_irq
);
    adc_conv_pkg::adc_state_type state_reg, state_next;
    logic [8:0]  cnt_reg, cnt_next;
    logic [8:0]  chen_reg, chen_next;
    logic        start_reg, start_next;
    logic        align_reg, align_next;
    logic        mode_reg, mode_next;
    logic        fwctl_reg, fwctl_next;
    logic [3:0]  sel_reg, sel_next;
    logic        bgen_reg, bgen_next;
    logic [4:0]  div_reg, div_next;
    logic [7:0]  sh_reg, sh_next;
    logic        cal_enable_reg, cal_enable_next;
    logic        cal_start_reg, cal_start_next;
    logic [11:0] result_reg, result_next;
    logic        flag_reg, flag_next;
    logic        irq_reg, irq_next;
    logic        sample_reg, sample_next;
    logic        conv_reg, conv_next;
    logic [9:0]  route_reg, route_next;
    logic [7:0]  sfr_rdata_reg, sfr_rdata_next;
    logic [7:0]  xram_rdata_reg, xram_rdata_next;
    logic [11:0] data_meta_reg;
    logic [11:0] data_sync_reg;
    logic        tick;
    logic        clk_level;
    logic        sel_enabled;
    logic        conv_done;
    logic        cal_done;
    logic [8:0]  sample_len;
    logic [8:0]  conv_len;
    logic [8:0]  cnt_inc;

    localparam logic [7:0] cal_reset_value = `ADC_CAL_RESET;

    adc_clock_divider u_divider (
        .mclk          (mclk),
        .sys_rst       (sys_rst),
        .divider_value (div_reg),
        .tick          (tick),
        .clk_level     (clk_level)
    );

    // ------------------------------------------------------------------
    // input routing, one term per external channel
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 9; gi = gi + 1)
        begin : g_route
            assign route_next[gi] = chen_reg[gi] && (sel_reg == 4'(gi)); // [R9]
        end
    endgenerate
    assign route_next[9] = bgen_reg && (sel_reg > 4'h8); // [R10]

    // ------------------------------------------------------------------
    // registers, sequencer and read path
    // ------------------------------------------------------------------
    always_comb
    begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        chen_next   = chen_reg;
        start_next  = start_reg;
        align_next  = align_reg;
        mode_next   = mode_reg;
        fwctl_next  = fwctl_reg;
        sel_next    = sel_reg;
        bgen_next   = bgen_reg;
        div_next    = div_reg;
        sh_next     = sh_reg;
        cal_enable_next = cal_enable_reg;
        cal_start_next  = cal_start_reg;
        result_next = result_reg;
        flag_next   = flag_reg;
        sfr_rdata_next  = sfr_rdata_reg;
        xram_rdata_next = xram_rdata_reg;
        sel_enabled = (sel_reg > 4'h8) ? bgen_reg : chen_reg[sel_reg];
        sample_len  = (sh_reg == 8'h00) ? `ADC_HW_SAMPLE_ZERO
                                        : `ADC_HW_SAMPLE_BASE + {1'b0, sh_reg}; // [R12]
        conv_len    = (mode_reg ? `ADC_FW_CONV_CLKS : `ADC_HW_CONV_CLKS) // [R13]
                    + ((cal_enable_reg && sel_enabled) ? `ADC_CAL_EXTRA_CLKS : 9'h000); // [R14]
        cnt_inc     = cnt_reg + 9'h001;
        conv_done   = tick && (state_reg == adc_conv_pkg::ST_CONVERT) && (cnt_inc >= conv_len);
        cal_done    = tick && (state_reg == adc_conv_pkg::ST_CALIB) && (cnt_inc >= `ADC_CAL_CLKS);

        if (sfr_wr)
        begin
            case (sfr_addr)
                `ADC_CH_EN_LOW_ADDR: chen_next[7:0] = sfr_wdata; // [R2]
                `ADC_CTRL_ADDR:
                begin
                    align_next = sfr_wdata[`ADC_CTRL_ALIGN];
                    mode_next  = sfr_wdata[`ADC_CTRL_MODE];
                    fwctl_next = sfr_wdata[`ADC_CTRL_FWCTL];
                    sel_next   = sfr_wdata[3:0];
                    // busy ignores the start bit entirely, writing 0 cannot abort
                    if (state_reg == adc_conv_pkg::ST_IDLE && !cal_start_reg) // [R20]
                        start_next = sfr_wdata[`ADC_CTRL_START]; // [R4]
                end
                `ADC_CLK_SEL_ADDR:
                begin
                    bgen_next   = sfr_wdata[`ADC_CLK_BGEN]; // [R10]
                    chen_next[8] = sfr_wdata[`ADC_CLK_CH8EN]; // [R3]
                    div_next    = sfr_wdata[4:0];
                end
                `ADC_SH_ADDR: sh_next = sfr_wdata;
                default: ;
            endcase
        end

        if (xram_wr && xram_addr == `ADC_CAL_ADDR)
        begin
            cal_enable_next = xram_wdata[`ADC_CAL_EN];
            if (state_reg == adc_conv_pkg::ST_IDLE && !start_reg) // [R20]
                cal_start_next = xram_wdata[`ADC_CAL_START]; // [R15]
        end

        case (state_reg)
            adc_conv_pkg::ST_IDLE:
                if (tick && start_reg)
                begin
                    state_next = mode_reg ? adc_conv_pkg::ST_SAMPLE
                                          : adc_conv_pkg::ST_SAMPLE;
                    cnt_next   = 9'h000;
                end
                else if (tick && cal_start_reg)
                begin
                    state_next = adc_conv_pkg::ST_CALIB;
                    cnt_next   = 9'h000;
                end
            adc_conv_pkg::ST_SAMPLE:
                if (tick)
                begin
                    cnt_next = cnt_inc;
                    if (mode_reg ? !fwctl_reg : (cnt_inc >= sample_len)) // [R7]
                    begin
                        state_next = adc_conv_pkg::ST_CONVERT;
                        cnt_next   = 9'h000;
                    end
                end
            adc_conv_pkg::ST_CONVERT:
                if (tick)
                begin
                    cnt_next = cnt_inc;
                    if (conv_done)
                    begin
                        state_next  = adc_conv_pkg::ST_IDLE;
                        start_next  = 1'b0; // [R19]
                        result_next = data_sync_reg; // [R1]
                    end
                end
            adc_conv_pkg::ST_CALIB:
                if (tick)
                begin
                    cnt_next = cnt_inc;
                    if (cal_done)
                    begin
                        state_next = adc_conv_pkg::ST_IDLE;
                        cal_start_next = 1'b0; // [R15]
                    end
                end
            default:
                state_next = adc_conv_pkg::ST_IDLE;
        endcase

        // vector entry clears, a completion in the same cycle wins
        if (irq_vector_ack)
            flag_next = 1'b0; // [R17]
        if (conv_done)
            flag_next = 1'b1; // [R17]
        irq_next = flag_next && conversion_irq_enable; // [R18]

        sample_next = mode_reg ? (fwctl_next && state_next != adc_conv_pkg::ST_CONVERT
                                 && state_next != adc_conv_pkg::ST_CALIB) // [R8]
                               : (state_next == adc_conv_pkg::ST_SAMPLE);
        conv_next   = (state_next == adc_conv_pkg::ST_CONVERT);

        if (sfr_rd)
        begin
            case (sfr_addr)
                `ADC_CH_EN_LOW_ADDR: sfr_rdata_next = chen_reg[7:0];
                `ADC_CTRL_ADDR:
                    sfr_rdata_next = {start_reg, align_reg, mode_reg, fwctl_reg, sel_reg};
                `ADC_RES_HIGH_ADDR:
                    sfr_rdata_next = align_reg ? {4'h0, result_reg[11:8]} // [R6]
                                               : result_reg[11:4]; // [R5]
                `ADC_RES_LOW_ADDR:
                    sfr_rdata_next = align_reg ? result_reg[7:0] // [R6]
                                               : {4'h0, result_reg[3:0]}; // [R5]
                `ADC_CLK_SEL_ADDR:
                    sfr_rdata_next = {bgen_reg, chen_reg[8], 1'b0, div_reg};
                `ADC_SH_ADDR: sfr_rdata_next = sh_reg;
                default: sfr_rdata_next = 8'h00;
            endcase
        end
        if (xram_rd)
            xram_rdata_next = (xram_addr == `ADC_CAL_ADDR) ? {6'h00, cal_enable_reg, cal_start_reg}
                                                           : 8'h00;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg      <= adc_conv_pkg::ST_IDLE;
            cnt_reg        <= 9'h000;
            chen_reg       <= 9'h000;
            start_reg      <= 1'b0;
            align_reg      <= 1'b0;
            mode_reg       <= 1'b0;
            fwctl_reg      <= 1'b0;
            sel_reg        <= 4'h0;
            bgen_reg       <= 1'b0;
            div_reg        <= 5'h00;
            sh_reg         <= `ADC_REG_RESET;
            cal_enable_reg <= cal_reset_value[`ADC_CAL_EN];
            cal_start_reg  <= cal_reset_value[`ADC_CAL_START];
            result_reg     <= 12'h000;
            flag_reg       <= 1'b0;
            irq_reg        <= 1'b0;
            sample_reg     <= 1'b0;
            conv_reg       <= 1'b0;
            route_reg      <= 10'h000;
            sfr_rdata_reg  <= 8'h00;
            xram_rdata_reg <= 8'h00;
            data_meta_reg  <= 12'h000;
            data_sync_reg  <= 12'h000;
        end
        else
        begin
            state_reg      <= state_next;
            cnt_reg        <= cnt_next;
            chen_reg       <= chen_next;
            start_reg      <= start_next;
            align_reg      <= align_next;
            mode_reg       <= mode_next;
            fwctl_reg      <= fwctl_next;
            sel_reg        <= sel_next;
            bgen_reg       <= bgen_next;
            div_reg        <= div_next;
            sh_reg         <= sh_next;
            cal_enable_reg <= cal_enable_next;
            cal_start_reg  <= cal_start_next;
            result_reg     <= result_next;
            flag_reg       <= flag_next;
            irq_reg        <= irq_next;
            sample_reg     <= sample_next;
            conv_reg       <= conv_next;
            route_reg      <= route_next;
            sfr_rdata_reg  <= sfr_rdata_next;
            xram_rdata_reg <= xram_rdata_next;
            data_meta_reg  <= adc_core_data;
            data_sync_reg  <= data_meta_reg;
        end
    end

    assign sfr_rdata                  = sfr_rdata_reg;
    assign xram_rdata                 = xram_rdata_reg;
    assign converter_channel_n_enable = chen_reg;
    assign analog_route               = route_reg;
    assign sample_active              = sample_reg;
    assign convert_active             = conv_reg;
    assign converter_clock            = clk_level;
    assign conversion_end_flag        = flag_reg;
    assign conversion_irq             = irq_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [9:0] span_reg;
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            span_reg <= 10'h000;
        else if (state_reg == adc_conv_pkg::ST_IDLE)
            span_reg <= 10'h000;
        else if (tick && state_reg != adc_conv_pkg::ST_CALIB)
            span_reg <= span_reg + 10'h001;
    end

    sequence completion;
        conv_done;
    endsequence

    AST_START_CLEARS: assert property (@(posedge mclk) disable iff (sys_rst) // [R19]
        completion |=> !start_reg && state_reg == adc_conv_pkg::ST_IDLE)
        else $error("start bit not cleared at conversion end");
    AST_RESULT_TAKEN: assert property (@(posedge mclk) disable iff (sys_rst) // [R1]
        completion |=> result_reg == $past(data_sync_reg))
        else $error("result not captured at conversion end");
    AST_FLAG_SETS: assert property (@(posedge mclk) disable iff (sys_rst) // [R17]
        completion |=> flag_reg)
        else $error("end flag not set");
    AST_FLAG_ACK: assert property (@(posedge mclk) disable iff (sys_rst) // [R17]
        (irq_vector_ack && !conv_done) |=> !flag_reg)
        else $error("end flag not cleared on vector entry");
    AST_IRQ_GATED: assert property (@(posedge mclk) disable iff (sys_rst) // [R18]
        conversion_irq |-> flag_reg && $past(conversion_irq_enable))
        else $error("interrupt request without enable or flag");
    AST_HW_LENGTH: assert property (@(posedge mclk) disable iff (sys_rst) // [R12]
        (completion and !mode_reg) |-> (span_reg + 10'h001) == {1'b0, sample_len + conv_len})
        else $error("hardware conversion length wrong");
    AST_CAL_CLEARS: assert property (@(posedge mclk) disable iff (sys_rst) // [R15]
        cal_done |=> !cal_start_reg ##1 !cal_start_reg)
        else $error("calibration start not cleared");
    AST_BUSY_IGNORES: assert property (@(posedge mclk) disable iff (sys_rst) // [R20]
        (state_reg == adc_conv_pkg::ST_CALIB && sfr_wr && sfr_addr == `ADC_CTRL_ADDR)
        |=> !start_reg)
        else $error("start taken during calibration");
    AST_ALIGN_HIGH: assert property (@(posedge mclk) disable iff (sys_rst) // [R6]
        (sfr_rd && sfr_addr == `ADC_RES_HIGH_ADDR && align_reg) |=> sfr_rdata[7:4] == 4'h0)
        else $error("aligned high byte upper nibble not zero");
    AST_ALIGN_LOW: assert property (@(posedge mclk) disable iff (sys_rst) // [R5]
        (sfr_rd && sfr_addr == `ADC_RES_LOW_ADDR && !align_reg) |=> sfr_rdata[7:4] == 4'h0)
        else $error("default low byte upper nibble not zero");
    AST_FW_SAMPLE: assert property (@(posedge mclk) disable iff (sys_rst) // [R7]
        (mode_reg && state_reg == adc_conv_pkg::ST_SAMPLE && fwctl_reg && !tick)
        |=> state_reg != adc_conv_pkg::ST_CONVERT)
        else $error("firmware sampling ended while control bit set");
    AST_BANDGAP: assert property (@(posedge mclk) disable iff (sys_rst) // [R9]
        analog_route[9] |-> $past(bgen_reg && sel_reg > 4'h8))
        else $error("bandgap routed without select or enable");

endmodule : adc_conversion_control
`default_nettype wire

//--- core/_unused_placeholder_removed.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- tb/adc_core_model.sv
/*
 * Stand-in for the analog core: returns a code derived from the routed input.
 * Assumes the route is one-hot and held steady through a conversion.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
    input  wire logic        mclk,
    input  wire logic [9:0]  analog_route,
    output logic      [11:0] adc_core_data = 12'h3c3
);
    // unrouted input flips every cycle so a stale sample never matches
    always @(posedge mclk)
    begin
        if (|analog_route)
            adc_core_data <= {2'b10, analog_route} ^ 12'h5a5;
        else
            adc_core_data <= ~adc_core_data;
    end
endmodule : adc_core_model
`default_nettype wire

//--- tb/adc_conversion_control_tb_top.sv
/*
 * Self-checking bench for the converter control block with a core model.
 * Assumes the block's own assertions watch the sequencer internals.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_tb_top;
    localparam logic [11:0] ch2_code = {2'b10, 10'h004} ^ 12'h5a5;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  sfr_addr = 8'h00;
    logic        sfr_wr = 1'b0;
    logic        sfr_rd = 1'b0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic [7:0]  sfr_rdata;
    logic [15:0] xram_addr = 16'h0000;
    logic        xram_wr = 1'b0;
    logic        xram_rd = 1'b0;
    logic [7:0]  xram_wdata = 8'h00;
    logic [7:0]  xram_rdata;
    logic [7:0]  q;
    logic        irq_en = 1'b0;
    logic        irq_ack = 1'b0;
    logic [11:0] core_data;
    logic [8:0]  chan_en;
    logic [9:0]  route;
    logic        sampling, converting, conv_clk, end_flag, irq;
    int          err_total = 0;
    int          checks = 0;
    int          n;
    int          m;

    always #4 mclk = ~mclk;

    adc_conversion_control dut (.mclk(mclk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .xram_addr(xram_addr), .xram_wr(xram_wr), .xram_rd(xram_rd),
        .xram_wdata(xram_wdata), .xram_rdata(xram_rdata), .conversion_irq_enable(irq_en),
        .irq_vector_ack(irq_ack), .adc_core_data(core_data),
        .converter_channel_n_enable(chan_en), .analog_route(route),
        .sample_active(sampling), .convert_active(converting), .converter_clock(conv_clk),
        .conversion_end_flag(end_flag), .conversion_irq(irq));
    adc_core_model core (.mclk(mclk), .analog_route(route), .adc_core_data(core_data));

    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = wr;
        sfr_rd = ~wr;
        @(negedge mclk);
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
    endtask : sfr
    task automatic sfr_r(input logic [7:0] a, input logic [7:0] exp);
        sfr(1'b0, a, 8'h00);
        check({4'h0, sfr_rdata}, {4'h0, exp});
    endtask : sfr_r
    task automatic xr(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(negedge mclk);
        xram_addr = a;
        xram_wdata = d;
        xram_wr = wr;
        xram_rd = ~wr;
        @(negedge mclk);
        xram_wr = 1'b0;
        xram_rd = 1'b0;
        q = xram_rdata;
    endtask : xr
    // start may wait up to one tick before sampling begins
    task automatic conv(input logic [7:0] ctl, input int t);
        sfr(1'b1, 8'hac, ctl);
        n = 0;
        m = 0;
        while (end_flag !== 1'b1 && n < 400)
        begin
            @(negedge mclk);
            n++;
            m += converting;
        end
        check({11'h0, n >= 6 * t - 6 && n <= 6 * t + 8}, 12'h001);
        // conversion phase: 12 ticks in hardware mode, 16 in firmware mode or calibrated hardware mode
        check({11'h0, m == 72 || m == 96}, 12'h001);
    endtask : conv
    task automatic ack();
        @(negedge mclk);
        irq_ack = 1'b1;
        @(negedge mclk);
        irq_ack = 1'b0;
        @(negedge mclk);
        check({11'h0, end_flag}, 12'h000);
    endtask : ack

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] addrs [7] = '{8'hab, 8'hac, 8'had, 8'hae, 8'haf, 8'hef, 8'h80};
        foreach (addrs[i])
            sfr_r(addrs[i], 8'h00);
        xr(1'b0, 16'hffff, 8'h00);
        check({4'h0, q}, 12'h002);
        // divider zero: six-cycle period, high half the time
        n = 0;
        repeat (12)
        begin
            @(negedge mclk);
            n += conv_clk;
        end
        check({11'h0, n == 6}, 12'h001);
    endtask : t_reset
    task automatic t_route();
        sfr(1'b1, 8'hab, 8'h04);
        sfr(1'b1, 8'haf, 8'h40);
        sfr(1'b1, 8'hac, 8'h02);
        repeat (2) @(negedge mclk);
        check({2'h0, route}, 12'h004);
        sfr(1'b1, 8'hac, 8'h08);
        repeat (2) @(negedge mclk);
        check({2'h0, route}, 12'h100);
        check({3'h0, chan_en}, 12'h104);
        sfr(1'b1, 8'hac, 8'h0f);
        repeat (2) @(negedge mclk);
        check({2'h0, route}, 12'h000);
        sfr(1'b1, 8'haf, 8'hc0);
        repeat (2) @(negedge mclk);
        check({2'h0, route}, 12'h200);
        sfr(1'b1, 8'haf, 8'h00);
    endtask : t_route
    task automatic t_hw();
        xr(1'b1, 16'hffff, 8'h00);
        irq_en = 1'b1;
        conv(8'h82, 16);
        check({11'h0, irq}, 12'h001);
        sfr_r(8'hac, 8'h02);
        sfr_r(8'had, ch2_code[11:4]);
        sfr_r(8'hae, {4'h0, ch2_code[3:0]});
        sfr(1'b1, 8'hac, 8'h42);
        sfr_r(8'had, {4'h0, ch2_code[11:8]});
        sfr_r(8'hae, ch2_code[7:0]);
        ack();
        irq_en = 1'b0;
        sfr(1'b1, 8'hef, 8'h05);
        conv(8'h82, 24);
        check({11'h0, irq}, 12'h000);
        ack();
    endtask : t_hw
    task automatic t_fw();
        sfr(1'b1, 8'hac, 8'h32);
        repeat (2) @(negedge mclk);
        check({11'h0, sampling}, 12'h001);
        sfr(1'b1, 8'hac, 8'hb2);
        repeat (200) @(negedge mclk);
        check({9'h0, sampling, converting, end_flag}, 12'h004);
        conv(8'ha2, 16);
        ack();
        sfr(1'b1, 8'hac, 8'h12);
        repeat (3) @(negedge mclk);
        check({11'h0, sampling}, 12'h000);
    endtask : t_fw
    task automatic t_cal();
        xr(1'b1, 16'hffff, 8'h00);
        xr(1'b1, 16'hffff, 8'h03);
        xr(1'b0, 16'hffff, 8'h00);
        check({4'h0, q}, 12'h003);
        // let the first tick pass so the start write lands inside calibration
        repeat (6) @(negedge mclk);
        sfr(1'b1, 8'hac, 8'h82);
        n = 0;
        while (q[0] !== 1'b0 && n < 300)
        begin
            xr(1'b0, 16'hffff, 8'h00);
            n++;
        end
        check({11'h0, n >= 186 && n <= 196}, 12'h001);
        check({4'h0, q}, 12'h002);
        sfr_r(8'hac, 8'h02);
        // sample-hold still 5: 19 + 5 ticks, plus 4 for calibration
        conv(8'h82, 28);
        ack();
    endtask : t_cal

    task automatic finish_test();
        if (err_total == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        t_reset();
        t_route();
        t_hw();
        t_fw();
        t_cal();
        finish_test();
    end
    initial
    begin
        #100000;
        err_total++;
        finish_test();
    end
endmodule : adc_conversion_control_tb_top
`default_nettype wire
